// *** rsse_core.sv ***
`timescale 1ns/1ps
`include "rsse_params.svh"
// Executes rotate, literal-subtract and sleep ops issued over APB
module rsse_core
	import rsse_pkg::*;
#(
	parameter int PRESC_W = 8,
	parameter int WDT_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic osc_stopped
);
	rsse_state_t state;
	rsse_state_t next_state;
	rsse_op_t op;
	logic dest;
	logic [6:0] faddr;
	logic [7:0] lit;
	logic [7:0] work;
	rsse_flags_t flags;
	logic sleep_entered_flag_n;
	logic watchdog_expiry_flag_n;
	logic [PRESC_W-1:0] presc;
	logic [WDT_W-1:0] watchdog_timer_count;
	logic wdt_run;
	logic [7:0] mem_rdata;
	logic mem_we;
	logic [7:0] mem_wdata;
	rsse_alu_out_t alu;
	logic acc;
	logic wr;
	logic cmd_wr;
	logic wake_wr;

	// Address decode helper used by the write paths
	function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
		return a == o;
	endfunction

	assign acc = psel & penable;
	assign wr = acc & pwrite;
	// Commands are dropped outside RUN; status has no busy bit to poll
	assign cmd_wr = wr & hit(paddr, `RSSE_OFF_CMD) & (state == RSSE_ST_RUN);
	// Writing ctrl bit 1 is the wake event out of sleep
	assign wake_wr = wr & hit(paddr, `RSSE_OFF_CTRL) & pwdata[1];

	rsse_file_mem #(.DEPTH(128), .AW(7)) u_mem (
		.pclk(pclk),
		.we(mem_we),
		.waddr(faddr),
		.wdata(mem_wdata),
		.raddr(cmd_wr ? pwdata[`RSSE_CMD_ADDR_LSB +: 7] : faddr),
		.rdata(mem_rdata)
	);

	rsse_alu u_alu (
		.sel_sub(op == RSSE_OP_SUBLIT),
		.operand(op == RSSE_OP_SUBLIT ? lit : mem_rdata),
		.work(work),
		.carry_in(flags.carry),
		.out(alu)
	);

	// Command capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op <= RSSE_OP_NONE;
			dest <= 1'b0;
			faddr <= 7'h00;
			lit <= 8'h00;
		end else if (cmd_wr) begin
			op <= rsse_op_t'(pwdata[`RSSE_CMD_OP_LSB +: 2]);
			dest <= pwdata[`RSSE_CMD_DEST_BIT];
			faddr <= pwdata[`RSSE_CMD_ADDR_LSB +: 7];
			lit <= pwdata[7:0];
		end
	end

	// Sequencer: rotate needs one wait for registered memory read
	always_comb begin
		next_state = state;
		case (state)
			RSSE_ST_RUN: begin
				if (cmd_wr) begin
					case (rsse_op_t'(pwdata[`RSSE_CMD_OP_LSB +: 2]))
						RSSE_OP_ROTATE: next_state = RSSE_ST_WAIT;
						RSSE_OP_SUBLIT: next_state = RSSE_ST_WRITE;
						RSSE_OP_SLEEP: next_state = RSSE_ST_WRITE;
						default: next_state = RSSE_ST_RUN;
					endcase
				end
			end
			RSSE_ST_WAIT: next_state = RSSE_ST_WRITE;
			RSSE_ST_WRITE: begin
				next_state = (op == RSSE_OP_SLEEP) ? RSSE_ST_SLEEP : RSSE_ST_RUN;
			end
			RSSE_ST_SLEEP: next_state = wake_wr ? RSSE_ST_RUN : RSSE_ST_SLEEP;
			default: next_state = RSSE_ST_RUN;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= RSSE_ST_RUN;
		end else begin
			state <= next_state;
		end
	end

	assign mem_we = (state == RSSE_ST_WRITE) & (op == RSSE_OP_ROTATE) & dest;
	assign mem_wdata = alu.result;

	// Working register and arithmetic flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			work <= `RSSE_WORK_RST;
			flags <= '0;
		end else if (state == RSSE_ST_WRITE) begin
			if (op == RSSE_OP_ROTATE) begin
				if (!dest) begin
					work <= alu.result;
				end
				flags.carry <= alu.flags.carry;
			end else if (op == RSSE_OP_SUBLIT) begin
				work <= alu.result;
				flags <= alu.flags;
			end
		end else if (wr & hit(paddr, `RSSE_OFF_WORK)) begin
			work <= pwdata[7:0];
		end
	end

	// Power status bits, active low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sleep_entered_flag_n <= 1'b1;
			watchdog_expiry_flag_n <= 1'b1;
		end else if (state == RSSE_ST_WRITE && op == RSSE_OP_SLEEP) begin
			sleep_entered_flag_n <= 1'b0;
			watchdog_expiry_flag_n <= 1'b1;
		end else if (wr & hit(paddr, `RSSE_OFF_CTRL) & pwdata[2]) begin
			sleep_entered_flag_n <= 1'b1;
		end
	end

	// Watchdog with prescaler; frozen while oscillator is stopped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc <= '0;
			watchdog_timer_count <= '0;
			wdt_run <= 1'b0;
		end else begin
			if (wr & hit(paddr, `RSSE_OFF_CTRL)) begin
				wdt_run <= pwdata[0];
			end
			if (state == RSSE_ST_WRITE && op == RSSE_OP_SLEEP) begin
				presc <= '0;
				watchdog_timer_count <= '0;
			end else if (wdt_run && state != RSSE_ST_SLEEP) begin
				presc <= presc + 1'b1;
				if (presc == {PRESC_W{1'b1}}) begin
					watchdog_timer_count <= watchdog_timer_count + 1'b1;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_stopped <= 1'b0;
		end else begin
			osc_stopped <= (next_state == RSSE_ST_SLEEP);
		end
	end

	// APB read data and response; zero wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			if (psel & ~penable) begin
				case (paddr)
					`RSSE_OFF_CMD: prdata <= {14'h0000, op, dest, faddr, lit};
					`RSSE_OFF_WORK: prdata <= {24'h000000, work};
					`RSSE_OFF_STATUS: prdata <= {26'h0000000,
						state == RSSE_ST_SLEEP, watchdog_expiry_flag_n,
						sleep_entered_flag_n, flags.zero,
						flags.nibble_carry_flag, flags.carry};
					`RSSE_OFF_WDT: prdata <= {24'h000000,
						8'(watchdog_timer_count)};
					`RSSE_OFF_CTRL: prdata <= {31'h00000000, wdt_run};
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end
endmodule // rsse_core

// *** rsse_params.svh ***
`ifndef RSSE_PARAMS_SVH
`define RSSE_PARAMS_SVH

// Register offsets (byte addresses)
`define RSSE_OFF_CMD 12'h000
`define RSSE_OFF_WORK 12'h004
`define RSSE_OFF_STATUS 12'h008
`define RSSE_OFF_WDT 12'h00C
`define RSSE_OFF_CTRL 12'h010
// Command field positions
`define RSSE_CMD_OP_LSB 16
`define RSSE_CMD_DEST_BIT 15
`define RSSE_CMD_ADDR_LSB 8
// Status field positions
`define RSSE_ST_CARRY 0
`define RSSE_ST_NIBBLE 1
`define RSSE_ST_ZERO 2
`define RSSE_ST_SLEEP_N 3
`define RSSE_ST_EXPIRY_N 4
`define RSSE_ST_ASLEEP 5
// Reset values and prescaler maximum
`define RSSE_WORK_RST 8'h00
`define RSSE_STATUS_RST 5'h18
`define RSSE_PRESC_MAX 8'hFF
`endif

// *** rsse_pkg.sv ***
package rsse_pkg;
	typedef enum logic [1:0] {
		RSSE_OP_NONE = 2'b00,
		RSSE_OP_ROTATE = 2'b01,
		RSSE_OP_SUBLIT = 2'b10,
		RSSE_OP_SLEEP = 2'b11
	} rsse_op_t;
	typedef enum logic [1:0] {
		RSSE_ST_RUN = 2'b00,
		RSSE_ST_WAIT = 2'b01,
		RSSE_ST_WRITE = 2'b10,
		RSSE_ST_SLEEP = 2'b11
	} rsse_state_t;
	typedef struct packed {
		logic carry;
		logic nibble_carry_flag;
		logic zero;
	} rsse_flags_t;
	typedef struct packed {
		logic [7:0] result;
		rsse_flags_t flags;
	} rsse_alu_out_t;
endpackage

// *** rsse_file_mem.sv ***
`timescale 1ns/1ps
// File register array with registered read data
module rsse_file_mem #(
	parameter int DEPTH = 128,
	parameter int AW = 7
) (
	input wire logic pclk,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [7:0] rdata
);
	logic [7:0] mem [DEPTH];

	// No reset: contents are undefined until software writes them
	always_ff @(posedge pclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule // rsse_file_mem

// *** rsse_alu.sv ***
`timescale 1ns/1ps
// Combinational rotate and literal-subtract datapath
module rsse_alu
	import rsse_pkg::*;
(
	input wire logic sel_sub,
	input wire logic [7:0] operand,
	input wire logic [7:0] work,
	input wire logic carry_in,
	output rsse_alu_out_t out
);
	logic [8:0] diff;
	logic [4:0] ndiff;

	always_comb begin
		diff = {1'b0, operand} - {1'b0, work};
		ndiff = {1'b0, operand[3:0]} - {1'b0, work[3:0]};
		out = '0;
		if (sel_sub) begin
			out.result = diff[7:0];
			out.flags.carry = ~diff[8];
			out.flags.nibble_carry_flag = ~ndiff[4];
			out.flags.zero = (diff[7:0] == 8'h00);
		end else begin
			out.result = {carry_in, operand[7:1]};
			out.flags.carry = operand[0];
		end
	end
endmodule // rsse_alu

// *** rsse_core_checker.sv ***
`timescale 1ns/1ps
`include "rsse_params.svh"
// Port-level checks of the APB slave and the sleep behaviour
module rsse_core_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic osc_stopped
);
	// Completed transfers and the register hits they make
	wire logic xfer = psel && penable && pready;
	wire logic rd_st = xfer && !pwrite && paddr == `RSSE_OFF_STATUS;
	wire logic rd_wd = xfer && !pwrite && paddr == `RSSE_OFF_WDT;
	wire logic go_sl = xfer && pwrite && paddr == `RSSE_OFF_CMD
		&& pwdata[17:16] == 2'h3;
	wire logic wake = xfer && pwrite && paddr == `RSSE_OFF_CTRL && pwdata[1];
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	ready_after_setup_a: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	ready_in_access_a: assert property (pready |-> psel && penable)
		else $error("pready outside access phase");
	err_with_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	unmapped_err_a: assert property (xfer && paddr > `RSSE_OFF_CTRL |-> pslverr)
		else $error("unmapped access without pslverr");
	sleep_stops_osc_a: assert property (
		go_sl && !osc_stopped |-> ##[1:3] osc_stopped)
		else $error("oscillator still running after sleep");
	osc_holds_a: assert property (osc_stopped && !wake |=> osc_stopped)
		else $error("sleep left without wake");
	sleep_flags_a: assert property (rd_st && osc_stopped |-> prdata[5:3] == 3'h6)
		else $error("status flags wrong in sleep");
	wdt_cleared_a: assert property (rd_wd && osc_stopped |-> prdata == 32'h0)
		else $error("watchdog not cleared in sleep");
	// Main scenarios reached
	cover property (go_sl);
	cover property (wake);
	cover property (xfer && pslverr);
endmodule // rsse_core_checker

// *** rsse_core_tb.sv ***
`timescale 1ns/1ps
`include "rsse_params.svh"
module rsse_core_tb
	import rsse_pkg::*;
;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rv;
	logic pready, pslverr, osc, ev;
	logic [7:0] w, k;
	logic [7:0] p = 8'h9B;
	logic [7:0] wt [5] = '{8'h05, 8'h06, 8'h0F, 8'h00, 8'h80};
	logic [7:0] kt [5] = '{8'h05, 8'h05, 8'h10, 8'hFF, 8'h7F};
	int errors = 0;
	int n_checks = 0;
	int cyc = 0;
	// 100 MHz clock
	initial forever #5 pclk = ~pclk;
	rsse_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.osc_stopped(osc));
	// One APB transfer; an idle cycle after keeps strobes single-driven
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rv = prdata;
		ev = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask
	// Command write, then let the op finish before the next one
	task automatic cmd(input rsse_op_t op, input logic ds,
		input logic [6:0] fa, input logic [7:0] lit);
		apb(1'h1, `RSSE_OFF_CMD, {14'h0, op, ds, fa, lit});
		repeat (2) @(posedge pclk);
	endtask
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", n, e, g);
			errors++;
		end
	endtask
	// Carry comes from 0-0 (set) or 0-1 (clear)
	task automatic setc(input logic cv);
		apb(1'h1, `RSSE_OFF_WORK, {31'h0, !cv});
		cmd(RSSE_OP_SUBLIT, 1'h0, 7'h0, 8'h00);
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Hang guard
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			errors++;
			finish_test();
		end
	end
	// Main sequence
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		apb(1'h0, `RSSE_OFF_STATUS, 32'h0);
		chk("status reset", 32'h18, rv);
		for (int i = 0; i < 5; i++) begin
			w = wt[i];
			k = kt[i];
			apb(1'h1, `RSSE_OFF_WORK, {24'h0, w});
			cmd(RSSE_OP_SUBLIT, 1'h0, 7'h7F, k);
			apb(1'h0, `RSSE_OFF_WORK, 32'h0);
			chk("difference", {24'h0, 8'(k - w)}, rv);
			apb(1'h0, `RSSE_OFF_STATUS, 32'h0);
			chk("sub flags", {26'h0, 3'h3, k == w, w[3:0] <= k[3:0],
				w <= k}, rv);
		end
		// Load the top file register bit by bit through carry
		for (int i = 0; i < 8; i++) begin
			setc(p[i]);
			cmd(RSSE_OP_ROTATE, 1'h1, 7'h7F, 8'h00);
		end
		setc(1'h1);
		cmd(RSSE_OP_ROTATE, 1'h0, 7'h7F, 8'h00);
		apb(1'h0, `RSSE_OFF_WORK, 32'h0);
		chk("rotate work", {24'h0, 1'h1, p[7:1]}, rv);
		apb(1'h0, `RSSE_OFF_STATUS, 32'h0);
		chk("rotate carry", {31'h0, p[0]}, rv & 32'h1);
		cmd(RSSE_OP_ROTATE, 1'h0, 7'h7F, 8'h00);
		apb(1'h0, `RSSE_OFF_WORK, 32'h0);
		chk("file kept", {24'h0, p[0], p[7:1]}, rv);
		apb(1'h0, 12'h020, 32'h0);
		chk("unmapped", 32'h1, {31'h0, ev});
		// Run the watchdog so that clearing it is visible
		apb(1'h1, `RSSE_OFF_CTRL, 32'h1);
		repeat (600) @(posedge pclk);
		apb(1'h0, `RSSE_OFF_WDT, 32'h0);
		chk("watchdog runs", 32'h1, {31'h0, rv != 32'h0});
		apb(1'h1, `RSSE_OFF_WORK, 32'h5A);
		cmd(RSSE_OP_SLEEP, 1'h0, 7'h0, 8'h00);
		chk("osc stopped", 32'h1, {31'h0, osc});
		apb(1'h0, `RSSE_OFF_STATUS, 32'h0);
		chk("sleep flags", 32'h6, {29'h0, rv[5:3]});
		apb(1'h0, `RSSE_OFF_WDT, 32'h0);
		chk("watchdog clear", 32'h0, rv);
		// A command while asleep must not execute
		cmd(RSSE_OP_SUBLIT, 1'h0, 7'h0, 8'h00);
		apb(1'h1, `RSSE_OFF_CTRL, 32'h2);
		repeat (2) @(posedge pclk);
		chk("woken", 32'h0, {31'h0, osc});
		apb(1'h0, `RSSE_OFF_WORK, 32'h0);
		chk("halted", 32'h5A, rv);
		finish_test();
	end
endmodule // rsse_core_tb
bind rsse_core rsse_core_checker chk_u (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.osc_stopped(osc_stopped));
